// *** hw/cvsp_cmp.sv ***
// registered-free equality compare of a scanline against a setting
`timescale 1ns/1ps
module cvsp_cmp #(
  parameter int WIDTH = 10
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] target,
  output logic hit
);
  assign hit = (value == target);
endmodule // cvsp_cmp

// *** hw/cvsp_top.sv ***
// vertical sync, display end, vertical interrupt, refresh and row pitch
`timescale 1ns/1ps
`include "cvsp_map.svh"
module cvsp_top #(
  parameter int ADDR_W = 20
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic io_data_sel,
  input wire logic io_wr_en,
  input wire logic io_rd_en,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic line_start,
  input wire logic [9:0] scanline,
  input wire logic row_advance,
  input wire logic [ADDR_W-1:0] start_addr,
  output logic vsync,
  output logic display_active,
  output logic interrupt_request_n,
  output logic interrupt_request_n_pending,
  output logic refresh_strobe,
  output logic [ADDR_W-1:0] mem_addr
);

  cvsp_pkg::cvsp_byte_t index_q;
  cvsp_pkg::cvsp_byte_t low_timing_q [0:7];
  cvsp_pkg::cvsp_byte_t vsync_start_low_q;
  cvsp_pkg::cvsp_byte_t vsync_end_and_interrupt_control_q;
  cvsp_pkg::cvsp_byte_t vertical_display_end_low_q;
  cvsp_pkg::cvsp_byte_t row_pitch_low_q;
  cvsp_pkg::cvsp_byte_t crtc_mode_control_register_q;
  cvsp_pkg::cvsp_byte_t refresh_override_register_q;
  cvsp_pkg::cvsp_byte_t extended_display_control_register_q;
  cvsp_pkg::cvsp_byte_t rd_mux;
  cvsp_pkg::cvsp_line_t sync_start;
  cvsp_pkg::cvsp_line_t disp_end;
  cvsp_pkg::cvsp_refresh_t refresh_cnt_q;
  cvsp_pkg::cvsp_refresh_t refresh_load;
  logic [8:0] pitch;
  logic [ADDR_W-1:0] pitch_step;
  logic [ADDR_W-1:0] row_base_q;
  logic [3:0] sync_lines_q;
  logic data_wr;
  logic protect;
  logic byte_mode;
  logic int_disable;
  logic int_armed;
  logic start_hit;
  logic end_hit;
  logic disp_hit;
  logic retrace_begin;
  logic vsync_q;
  logic display_active_q;
  logic pending_q;
  logic interrupt_request_n_n_q;
  logic refresh_q;
  logic [7:0] rdata_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic fetch_q;

  assign data_wr = io_wr_en && io_data_sel;
  assign protect = vsync_end_and_interrupt_control_q[`CVSP_BIT_PROTECT];
  assign byte_mode = crtc_mode_control_register_q[`CVSP_BIT_BYTE_WORD];
  assign int_disable =
    vsync_end_and_interrupt_control_q[`CVSP_BIT_INT_DISABLE];
  assign int_armed = vsync_end_and_interrupt_control_q[`CVSP_BIT_INT_CLEAR];

  // sync start gathers bits 9 and 8 from the overflow, display end only bit 8 (its bit 9 is zero)
  assign sync_start = {low_timing_q[7][`CVSP_OVF_VSS9],
    low_timing_q[7][`CVSP_OVF_VSS8], vsync_start_low_q};
  assign disp_end = {1'b0, low_timing_q[7][`CVSP_OVF_VDE8],
    vertical_display_end_low_q};
  assign pitch = {extended_display_control_register_q[`CVSP_BIT_PITCH8],
    row_pitch_low_q};
  // byte mode steps by pitch times two, word mode by pitch times four
  assign pitch_step = byte_mode
    ? ADDR_W'({pitch, 1'b0})
    : ADDR_W'({pitch, 2'b00});

  cvsp_cmp #(
    .WIDTH(10)
  ) u_start_cmp (
    .value(scanline),
    .target(sync_start),
    .hit(start_hit)
  );

  cvsp_cmp #(
    .WIDTH(4)
  ) u_end_cmp (
    .value(scanline[3:0]),
    .target(vsync_end_and_interrupt_control_q[`CVSP_VSE_MSB:0]),
    .hit(end_hit)
  );

  cvsp_cmp #(
    .WIDTH(10)
  ) u_disp_cmp (
    .value(scanline),
    .target(disp_end),
    .hit(disp_hit)
  );

  assign retrace_begin = line_start && start_hit && !vsync_q;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      index_q <= `CVSP_RESET_BYTE;
    else if (io_wr_en && !io_data_sel)
      index_q <= io_wdata;
  end

  // low timing bank; the line compare extension stays writable always
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 8; i++)
        low_timing_q[i] <= `CVSP_RESET_BYTE;
    end
    else if (data_wr && index_q <= `CVSP_LOW_TIMING_LAST)
    begin
      if (!protect)
        low_timing_q[index_q[2:0]] <= io_wdata;
      else if (index_q == `CVSP_IDX_OVERFLOW)
        low_timing_q[7][`CVSP_OVF_LINE_CMP] <=
          io_wdata[`CVSP_OVF_LINE_CMP];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vsync_start_low_q <= `CVSP_RESET_BYTE;
      vsync_end_and_interrupt_control_q <= `CVSP_RESET_BYTE;
      vertical_display_end_low_q <= `CVSP_RESET_BYTE;
      row_pitch_low_q <= `CVSP_RESET_BYTE;
      crtc_mode_control_register_q <= `CVSP_RESET_BYTE;
      refresh_override_register_q <= `CVSP_RESET_BYTE;
      extended_display_control_register_q <= `CVSP_RESET_BYTE;
    end
    else if (data_wr)
    begin
      unique case (index_q)
        `CVSP_IDX_VSYNC_START: vsync_start_low_q <= io_wdata;
        `CVSP_IDX_VSYNC_END_INT:
          vsync_end_and_interrupt_control_q <= io_wdata;
        `CVSP_IDX_VDISP_END: vertical_display_end_low_q <= io_wdata;
        `CVSP_IDX_ROW_PITCH: row_pitch_low_q <= io_wdata;
        `CVSP_IDX_MODE_CTRL: crtc_mode_control_register_q <= io_wdata;
        `CVSP_IDX_REFRESH_OVR: refresh_override_register_q <= io_wdata;
        `CVSP_IDX_EXT_DISP:
          extended_display_control_register_q <= io_wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    rd_mux = `CVSP_RESET_BYTE;
    if (index_q <= `CVSP_LOW_TIMING_LAST)
      rd_mux = low_timing_q[index_q[2:0]];
    else
    begin
      unique case (index_q)
        `CVSP_IDX_VSYNC_START: rd_mux = vsync_start_low_q;
        `CVSP_IDX_VSYNC_END_INT: rd_mux = vsync_end_and_interrupt_control_q;
        `CVSP_IDX_VDISP_END: rd_mux = vertical_display_end_low_q;
        `CVSP_IDX_ROW_PITCH: rd_mux = row_pitch_low_q;
        `CVSP_IDX_MODE_CTRL: rd_mux = crtc_mode_control_register_q;
        `CVSP_IDX_REFRESH_OVR: rd_mux = refresh_override_register_q;
        `CVSP_IDX_EXT_DISP: rd_mux = extended_display_control_register_q;
        default: rd_mux = `CVSP_RESET_BYTE;
      endcase
    end
  end

  // index port reads back the index, data port the selected register
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= `CVSP_RESET_BYTE;
    else if (io_rd_en)
      rdata_q <= io_data_sel ? rd_mux : index_q;
  end

  // sync line counter caps the pulse even when the end match never comes
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vsync_q <= 1'b0;
      sync_lines_q <= 4'h0;
    end
    else if (line_start)
    begin
      if (!vsync_q && start_hit)
      begin
        vsync_q <= 1'b1;
        sync_lines_q <= 4'h1;
      end
      else if (vsync_q && (end_hit ||
          sync_lines_q == `CVSP_SYNC_MAX_LINES))
      begin
        vsync_q <= 1'b0;
        sync_lines_q <= 4'h0;
      end
      else if (vsync_q)
        sync_lines_q <= sync_lines_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      display_active_q <= 1'b0;
    else if (line_start)
    begin
      if (disp_hit)
        display_active_q <= 1'b0;
      else if (scanline == 10'h000)
        display_active_q <= 1'b1;
    end
  end

  // clear bit low dominates: software gets a hard acknowledge
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pending_q <= 1'b0;
    else if (!int_armed)
      pending_q <= 1'b0;
    else if (retrace_begin)
      pending_q <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      interrupt_request_n_n_q <= 1'b1;
    else if (int_disable || !int_armed)
      interrupt_request_n_n_q <= 1'b1;
    else if (retrace_begin || pending_q)
      interrupt_request_n_n_q <= 1'b0;
    else
      interrupt_request_n_n_q <= 1'b1;
  end

  always_comb
  begin
    if (refresh_override_register_q[`CVSP_BIT_REFRESH_OVR])
      refresh_load = `CVSP_REFRESH_ONE;
    else if (vsync_end_and_interrupt_control_q[`CVSP_BIT_REFRESH5])
      refresh_load = `CVSP_REFRESH_FIVE;
    else
      refresh_load = `CVSP_REFRESH_THREE;
  end

  // one strobe per cycle after the line start, one strobe per refresh
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      refresh_cnt_q <= 3'h0;
      refresh_q <= 1'b0;
    end
    else if (line_start)
    begin
      refresh_cnt_q <= refresh_load;
      refresh_q <= 1'b0;
    end
    else if (refresh_cnt_q != 3'h0)
    begin
      refresh_cnt_q <= refresh_cnt_q - 3'h1;
      refresh_q <= 1'b1;
    end
    else
      refresh_q <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      row_base_q <= '0;
    else if (line_start)
    begin
      if (scanline == 10'h000)
        row_base_q <= start_addr;
      else if (row_advance)
        row_base_q <= row_base_q + pitch_step;
    end
  end

  // word mode rotates the counter so bit zero comes from the top bit
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fetch_q <= 1'b0;
      mem_addr_q <= '0;
    end
    else
    begin
      fetch_q <= line_start;
      if (fetch_q && byte_mode)
        mem_addr_q <= row_base_q;
      else if (fetch_q)
        mem_addr_q <= {row_base_q[ADDR_W-2:0], row_base_q[ADDR_W-1]};
    end
  end

  assign io_rdata = rdata_q;
  assign vsync = vsync_q;
  assign display_active = display_active_q;
  assign interrupt_request_n = interrupt_request_n_n_q;
  assign interrupt_request_n_pending = pending_q;
  assign refresh_strobe = refresh_q;
  assign mem_addr = mem_addr_q;

endmodule // cvsp_top

// *** include/cvsp_map.svh ***
// register indices, field positions, reset values and counts
`ifndef CVSP_MAP_SVH
`define CVSP_MAP_SVH
`define CVSP_IDX_OVERFLOW 8'h07
`define CVSP_IDX_VSYNC_START 8'h10
`define CVSP_IDX_VSYNC_END_INT 8'h11
`define CVSP_IDX_VDISP_END 8'h12
`define CVSP_IDX_ROW_PITCH 8'h13
`define CVSP_IDX_MODE_CTRL 8'h17
`define CVSP_IDX_REFRESH_OVR 8'h18
`define CVSP_IDX_EXT_DISP 8'h1B
`define CVSP_LOW_TIMING_LAST 8'h07
`define CVSP_BIT_PROTECT 7
`define CVSP_BIT_REFRESH5 6
`define CVSP_BIT_INT_DISABLE 5
`define CVSP_BIT_INT_CLEAR 4
`define CVSP_VSE_MSB 3
`define CVSP_OVF_VDE8 1
`define CVSP_OVF_VSS8 2
`define CVSP_OVF_LINE_CMP 4
`define CVSP_OVF_VSS9 7
`define CVSP_BIT_REFRESH_OVR 3
`define CVSP_BIT_PITCH8 4
`define CVSP_BIT_BYTE_WORD 6
`define CVSP_RESET_BYTE 8'h00
`define CVSP_REFRESH_FIVE 3'h5
`define CVSP_REFRESH_THREE 3'h3
`define CVSP_REFRESH_ONE 3'h1
`define CVSP_SYNC_MAX_LINES 4'hF
`endif

// *** include/cvsp_pkg.sv ***
// shared types of the vertical sync and pitch block
package cvsp_pkg;
  typedef logic [7:0] cvsp_byte_t;
  typedef logic [9:0] cvsp_line_t;
  typedef logic [2:0] cvsp_refresh_t;
endpackage

// *** tb/cvsp_monitor.sv ***
// far-side monitor that measures sync width in lines
`timescale 1ns/1ps
module cvsp_monitor (
  input wire logic core_clk,
  input wire logic line_start,
  input wire logic vsync,
  output logic [4:0] sync_lines
);
  logic [4:0] run_q;
  // a monitor sees only the level, so it counts line starts
  always_ff @(posedge core_clk)
    if (!vsync)
      run_q <= 5'h00;
    else if (line_start)
      run_q <= run_q + 5'h01;
  always_ff @(posedge core_clk)
    if ($fell(vsync))
      sync_lines <= run_q;
endmodule // cvsp_monitor

// *** tb/cvsp_top_sva.sv ***
// port checker of the vertical sync and pitch block
`timescale 1ns/1ps
module cvsp_chk #(
  parameter int ADDR_W = 20
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic line_start,
  input wire logic vsync,
  input wire logic display_active,
  input wire logic interrupt_request_n,
  input wire logic interrupt_request_n_pending,
  input wire logic refresh_strobe,
  input wire logic [ADDR_W-1:0] mem_addr
);
  logic [4:0] vs_n_q;
  logic [2:0] rf_n_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // lines seen while sync is high; too long for a repetition
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      vs_n_q <= 5'h00;
    else if (!vsync)
      vs_n_q <= 5'h00;
    else if (line_start)
      vs_n_q <= vs_n_q + 5'h01;
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      rf_n_q <= 3'h0;
    else if (line_start)
      rf_n_q <= 3'h0;
    else if (refresh_strobe)
      rf_n_q <= rf_n_q + 3'h1;
  property p_vs_rise; $rose(vsync) |-> $past(line_start); endproperty
  a_vs_rise: assert property (p_vs_rise)
    else $error("vsync rose away from a line start");
  property p_vs_fall; $fell(vsync) |-> $past(line_start); endproperty
  a_vs_fall: assert property (p_vs_fall)
    else $error("vsync fell away from a line start");
  property p_vs_width; vsync |-> vs_n_q <= 5'h0F; endproperty
  a_vs_width: assert property (p_vs_width)
    else $error("vsync longer than fifteen lines");
  property p_disp; $changed(display_active) |-> $past(line_start); endproperty
  a_disp: assert property (p_disp)
    else $error("display region moved off a line start");
  property p_req; !interrupt_request_n |-> interrupt_request_n_pending; endproperty
  a_req: assert property (p_req)
    else $error("request active without pending");
  property p_pend; $rose(interrupt_request_n_pending) |-> $rose(vsync); endproperty
  a_pend: assert property (p_pend)
    else $error("pending set outside retrace start");
  property p_rf; rf_n_q <= 3'h5; endproperty
  a_rf: assert property (p_rf)
    else $error("more than five refresh cycles in a line");
  property p_addr; $changed(mem_addr) |-> $past(line_start, 2); endproperty
  a_addr: assert property (p_addr)
    else $error("fetch address moved off a line start");
endmodule // cvsp_chk
bind cvsp_top cvsp_chk #(.ADDR_W(ADDR_W)) cvsp_chk_i (.core_clk, .arst_n,
  .line_start, .vsync, .display_active, .interrupt_request_n,
  .interrupt_request_n_pending, .refresh_strobe, .mem_addr);

// *** tb/cvsp_top_tb.sv ***
// self-checking bench of the vertical sync and pitch block
`timescale 1ns/1ps
module cvsp_top_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic io_data_sel = 1'b0;
  logic io_wr_en = 1'b0;
  logic io_rd_en = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic line_start = 1'b0;
  logic [9:0] scanline = 10'h000;
  logic row_advance = 1'b0;
  logic [19:0] start_addr = 20'h00000;
  logic [7:0] io_rdata, pitch;
  logic vsync, display_active, interrupt_request_n;
  logic interrupt_request_n_pending, refresh_strobe, rd_q;
  logic [19:0] mem_addr, base, step;
  logic [4:0] sync_lines;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0000A32C;
  logic [31:0] r;
  int failures = 0;
  int checks = 0;
  int strobes;
  always #12.5 core_clk = ~core_clk;
  cvsp_top cvsp_top_i (.core_clk, .arst_n, .io_data_sel, .io_wr_en,
    .io_rd_en, .io_wdata, .io_rdata, .line_start, .scanline, .row_advance,
    .start_addr, .vsync, .display_active, .interrupt_request_n,
    .interrupt_request_n_pending, .refresh_strobe, .mem_addr);
  cvsp_monitor cvsp_monitor_i (.core_clk, .line_start, .vsync, .sync_lines);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // index cycle then data cycle; a read notes its expected byte
  task automatic io(logic [7:0] idx, logic [7:0] val, logic is_rd);
    @(negedge core_clk);
    {io_wr_en, io_data_sel, io_wdata} = {2'b10, idx};
    @(negedge core_clk);
    {io_wr_en, io_rd_en, io_data_sel, io_wdata} = {!is_rd, is_rd, 1'b1, val};
    if (is_rd)
      exp_q.push_back(val);
    @(negedge core_clk);
    {io_wr_en, io_rd_en} = 2'b00;
  endtask
  // ten cycles a line leaves room for five refresh strobes
  task automatic line(logic [9:0] n);
    @(negedge core_clk);
    {line_start, scanline, row_advance} = {1'b1, n, 1'b1};
    @(negedge core_clk);
    line_start = 1'b0;
    strobes = 0;
    repeat (8)
    begin
      @(negedge core_clk);
      strobes += refresh_strobe;
    end
  endtask
  task automatic frame();
    for (int n = 0; n < 48; n++)
    begin
      line(n[9:0]);
      if (n == 0 || n == 16)
        chk("display_active", n == 0, display_active);
      if (n == 32 || n == 36)
        chk("vsync", n == 32, vsync);
    end
  endtask
  always @(posedge core_clk)
    rd_q <= io_rd_en;
  always @(negedge core_clk)
    if (rd_q)
      chk("io_rdata", exp_q.size() ? exp_q.pop_front() : 8'hXX, io_rdata);
  initial
  begin
    repeat (60000)
      @(posedge core_clk);
    failures++;
    complete_run();
  end
  initial
  begin
    repeat (16)
      @(negedge core_clk);
    arst_n = 1'b1;
    io(8'h11, 8'h80, 1'b0);
    io(8'h07, 8'hFF, 1'b0);
    io(8'h07, 8'h10, 1'b1);
    io(8'h11, 8'h04, 1'b0);
    io(8'h10, 8'h20, 1'b0);
    io(8'h12, 8'h10, 1'b0);
    io(8'h10, 8'h20, 1'b1);
    io(8'h12, 8'h10, 1'b1);
    io(8'h20, 8'h00, 1'b1);
    $display("end of register test");
    for (int m = 0; m < 3; m++)
    begin
      io(8'h18, {4'h0, m == 2, 3'h0}, 1'b0);
      io(8'h11, {1'b0, m != 0, 6'h14}, 1'b0);
      line(10'h001);
      chk("refresh", m == 0 ? 3 : m == 1 ? 5 : 1, strobes);
    end
    $display("end of refresh test");
    for (int k = 0; k < 4; k++)
    begin
      io(8'h11, 8'h04, 1'b0);
      @(negedge core_clk);
      chk("interrupt_request_n_pending", 1'b0, interrupt_request_n_pending);
      chk("interrupt_request_n", 1'b1, interrupt_request_n);
      io(8'h11, {2'b00, k == 2, k != 0, 4'h4}, 1'b0);
      frame();
      chk("interrupt_request_n_pending", k != 0, interrupt_request_n_pending);
      chk("interrupt_request_n", k != 1 && k != 3, interrupt_request_n);
    end
    chk("sync_lines", 5'h04, sync_lines);
    $display("end of sync and interrupt test");
    io(8'h07, 8'h86, 1'b0);
    line(10'h000);
    line(10'h010);
    chk("display_active", 1'b1, display_active);
    line(10'h110);
    chk("display_active", 1'b0, display_active);
    line(10'h020);
    chk("vsync", 1'b0, vsync);
    line(10'h320);
    chk("vsync", 1'b1, vsync);
    line(10'h324);
    chk("vsync", 1'b0, vsync);
    io(8'h11, 8'h10, 1'b0);
    for (int s = 0; s < 18; s++)
      line(10'h320 + s[9:0]);
    chk("sync_lines", 5'h0F, sync_lines);
    $display("end of overflow and sync cap test");
    r = rnd();
    pitch = r[7:0];
    start_addr = r[31:12];
    io(8'h1B, 8'h10, 1'b0);
    io(8'h13, pitch, 1'b0);
    io(8'h13, pitch, 1'b1);
    for (int w = 0; w < 2; w++)
    begin
      io(8'h17, {1'b0, w[0], 6'h00}, 1'b0);
      line(10'h000);
      step = {12'h001, pitch} << (w ? 1 : 2);
      base = start_addr + step;
      line(10'h001);
      chk("mem_addr", w ? base : {base[18:0], base[19]}, mem_addr);
    end
    $display("end of address test");
    complete_run();
  end
endmodule // cvsp_top_tb
